// [hdl/flash_seq_pkg.sv]
// constants shared by the flash sequencer files
package flash_seq_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_STATE = 12'hFF8;
  localparam logic [11:0] IDX_PAGE = 12'hFF9;
  localparam logic [11:0] IDX_PDATA = 12'hFFA;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h73;
  localparam logic [7:0] KEY_SECOND = 8'h8C;
  localparam logic [7:0] KEY_SECTOR = 8'h5E;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'hE1;
  localparam logic [7:0] CMD_MASS_ERASE = 8'hE2;
  // ----------------------------------------------------------------
  // controller_state codes
  // ----------------------------------------------------------------
  localparam logic [5:0] ST_LOCKED = 6'h00;
  localparam logic [5:0] ST_FIRST = 6'h01;
  localparam logic [5:0] ST_SECOND = 6'h02;
  localparam logic [5:0] ST_UNLOCKED = 6'h03;
  localparam logic [5:0] ST_SECTOR = 6'h04;
  localparam logic [5:0] ST_PROGRAM = 6'h08;
  localparam logic [5:0] ST_PAGE_ERASE = 6'h10;
  localparam logic [5:0] ST_MASS_ERASE = 6'h20;
  // ----------------------------------------------------------------
  // page_select layout and memory map
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam int INFO_BIT = 7;
  localparam int PAGE_W = 7;
  localparam int PAGE_LSB = 9;
  localparam logic [15:0] INFO_BASE = 16'hFE00;
  localparam logic [7:0] SECTOR_RESET = 8'h00;
  // ----------------------------------------------------------------
  // operation durations in clock cycles
  // ----------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam logic [11:0] PROGRAM_CYCLES = 12'h020;
  localparam logic [11:0] PAGE_ERASE_CYCLES = 12'h100;
  localparam logic [11:0] MASS_ERASE_CYCLES = 12'h400;
endpackage : flash_seq_pkg

// [hdl/flash_op_timer.sv]
// down counter that holds the busy span of one flash operation
`timescale 1ns/1ps
module flash_op_timer #(
  parameter int W = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] cycles,
  output logic busy,
  output logic done
);
  logic [W-1:0] count;
  wire lastCycle = busy && (count == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
      busy <= 1'b0;
    end else if (start && !busy) begin
      count <= cycles;
      busy <= (cycles != '0);
    end else if (busy) begin
      count <= count - 1'b1;
      busy <= !lastCycle;
    end
  end

  assign done = lastCycle;
endmodule : flash_op_timer

// [hdl/flash_unlock_page_select.sv]
// flash controller unlock sequencer, page select and apb register file
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module flash_unlock_page_select
  import flash_seq_pkg::*;
#(
  parameter logic [11:0] PROG_LEN = flash_seq_pkg::PROGRAM_CYCLES,
  parameter logic [11:0] PAGE_LEN = flash_seq_pkg::PAGE_ERASE_CYCLES,
  parameter logic [11:0] MASS_LEN = flash_seq_pkg::MASS_ERASE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flash_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic [flash_seq_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [flash_seq_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] progAddr,
  output logic pageMatch,
  output logic infoHit,
  output logic [6:0] erasePage,
  output logic opBusy,
  output logic progStart,
  output logic [7:0] progData,
  output logic pageEraseStart,
  output logic massEraseStart,
  output logic [7:0] sectorProtect
);
  import flash_seq_pkg::*;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_LOCKED = 3'b000,
    S_FIRST = 3'b001,
    S_SECOND = 3'b010,
    S_UNLOCKED = 3'b011,
    S_SECTOR = 3'b100,
    S_PROGRAM = 3'b101,
    S_PAGE_ERASE = 3'b110,
    S_MASS_ERASE = 3'b111
  } ctrl_e;

  ctrl_e state;
  ctrl_e next_state;
  logic [7:0] pageSel;
  logic [7:0] progByte;
  logic [7:0] sectorReg;
  logic [31:0] readData;
  logic timerBusy;
  logic timerDone;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire [11:0] regIdx = paddr[13:2];
  wire inRange = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
  wire hitState = inRange && (regIdx == IDX_STATE);
  wire hitPage = inRange && (regIdx == IDX_PAGE);
  wire hitData = inRange && (regIdx == IDX_PDATA);
  wire hitAny = hitState || hitPage || hitData;
  wire setupPhase = psel && !penable;
  wire accessPhase = psel && penable;
  wire wrStrobe = accessPhase && pwrite && hitAny && pstrb[0];
  wire [7:0] wrByte = pwdata[7:0];
  wire wrState = wrStrobe && hitState;
  wire wrShared = wrStrobe && hitPage;
  wire wrData = wrStrobe && hitData;
  wire busy = (state == S_PROGRAM) || (state == S_PAGE_ERASE) || (state == S_MASS_ERASE);

  assign pready = 1'b1;
  assign pslverr = accessPhase && !hitAny;

  // ----------------------------------------------------------------
  // status code
  // ----------------------------------------------------------------
  logic [5:0] statusCode;
  always_comb begin
    unique case (state)
      S_LOCKED: statusCode = ST_LOCKED;
      S_FIRST: statusCode = ST_FIRST;
      S_SECOND: statusCode = ST_SECOND;
      S_UNLOCKED: statusCode = ST_UNLOCKED;
      S_SECTOR: statusCode = ST_SECTOR;
      S_PROGRAM: statusCode = ST_PROGRAM;
      S_PAGE_ERASE: statusCode = ST_PAGE_ERASE;
      S_MASS_ERASE: statusCode = ST_MASS_ERASE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire startProg = (state == S_UNLOCKED) && wrData;
  wire startPage = (state == S_UNLOCKED) && wrState && (wrByte == CMD_PAGE_ERASE);
  wire startMass = (state == S_UNLOCKED) && wrState && (wrByte == CMD_MASS_ERASE);

  always_comb begin
    next_state = state;
    unique case (state)
      S_LOCKED: begin
        if (wrState && wrByte == KEY_FIRST) begin
          next_state = S_FIRST;
        end
      end
      S_FIRST: begin
        if (wrState) begin
          next_state = (wrByte == KEY_SECOND) ? S_SECOND : S_LOCKED;
        end
      end
      S_SECOND: begin
        if (wrShared) begin
          next_state = S_UNLOCKED;
        end else if (wrState) begin
          next_state = S_LOCKED;
        end
      end
      S_UNLOCKED: begin
        if (startProg) begin
          next_state = S_PROGRAM;
        end else if (startPage) begin
          next_state = S_PAGE_ERASE;
        end else if (startMass) begin
          next_state = S_MASS_ERASE;
        end else if (wrState && wrByte == KEY_SECTOR) begin
          next_state = S_SECTOR;
        end else if (wrState) begin
          next_state = S_LOCKED;
        end
      end
      S_SECTOR: begin
        if (wrShared) begin
          next_state = S_UNLOCKED;
        end else if (wrState) begin
          next_state = S_LOCKED;
        end
      end
      default: begin
        if (timerDone) begin
          next_state = S_UNLOCKED;
        end
      end
    endcase
  end

  wire [11:0] opLen = startProg ? PROG_LEN : (startPage ? PAGE_LEN : MASS_LEN);

  flash_op_timer #(
    .W(CNT_W)
  ) opTimer (
    .clock(clock),
    .rst(rst),
    .start(startProg || startPage || startMass),
    .cycles(opLen),
    .busy(timerBusy),
    .done(timerDone)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= S_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  // shared address routes to page select when not busy, or to sector protect in the sector state
  wire pageWrite = wrShared && (state != S_SECTOR) && !busy;
  wire sectorWrite = wrShared && (state == S_SECTOR);

  always_ff @(posedge clock) begin
    if (rst) begin
      pageSel <= PAGE_SEL_RESET;
    end else if (pageWrite) begin
      pageSel <= wrByte;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sectorReg <= SECTOR_RESET;
      progByte <= 8'h00;
    end else begin
      if (sectorWrite) begin
        sectorReg <= wrByte;
      end
      if (startProg) begin
        progByte <= wrByte;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [7:0] sharedRead = (state == S_SECTOR) ? sectorReg : pageSel;
  wire [7:0] readByte = hitState ? {2'b00, statusCode} :
                        hitPage ? sharedRead :
                        hitData ? progByte : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      readData <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      readData <= {24'h00_0000, readByte};
    end
  end

  assign prdata = readData;

  // ----------------------------------------------------------------
  // memory side
  // ----------------------------------------------------------------
  // page erase address match
  // page field supplies address bits 15 to 9
  assign erasePage = pageSel[PAGE_W-1:0];
  assign pageMatch = (progAddr[15:PAGE_LSB] == pageSel[PAGE_W-1:0]);
  assign infoHit = pageSel[INFO_BIT] && (progAddr >= INFO_BASE);
  assign opBusy = busy;
  assign progStart = startProg;
  assign progData = progByte;
  assign pageEraseStart = startPage;
  assign massEraseStart = startMass;
  assign sectorProtect = sectorReg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int PAGE_MAX = 258;

  sequence keyOne;
    (state == S_LOCKED) && wrState && (wrByte == KEY_FIRST);
  endsequence

  sequence keyTwo;
    (state == S_FIRST) && wrState && (wrByte == KEY_SECOND);
  endsequence

  default clocking cb @(posedge clock);
  endclocking

  chk_lock_reset: assert property (rst |=> prdata == 32'h0 && statusCode == ST_LOCKED)
    else $error("controller not locked after reset");
  chk_key_first: assert property (keyOne |=> statusCode == ST_FIRST)
    else $error("first key not shown");
  chk_key_second: assert property (keyTwo |=> statusCode == ST_SECOND)
    else $error("second key not shown");
  chk_full_unlock: assert property (disable iff (rst)
    (state == S_SECOND) && wrShared |=> statusCode == ST_UNLOCKED)
    else $error("unlock not completed");
  chk_busy_onehot: assert property (disable iff (rst)
    opBusy |-> $onehot(statusCode[5:3]) && statusCode[2:0] == 3'b000)
    else $error("busy code not one-hot");
  chk_timer_agree: assert property (disable iff (rst) opBusy == timerBusy)
    else $error("timer and state disagree on busy");
  chk_sector_key: assert property (disable iff (rst)
    (state == S_UNLOCKED) && wrState && wrByte == KEY_SECTOR |=> statusCode == ST_SECTOR)
    else $error("sector key not taken");
  chk_sector_route: assert property (disable iff (rst)
    sectorWrite |=> pageSel == $past(pageSel) && sectorProtect == $past(wrByte))
    else $error("sector write reached page select");
  chk_page_write: assert property (disable iff (rst)
    wrShared && state != S_SECTOR && !busy |=> pageSel == $past(wrByte))
    else $error("page select not written");
  chk_page_match: assert property (disable iff (rst)
    pageMatch |-> progAddr[15:9] == erasePage)
    else $error("page match wrong");
  chk_info_map: assert property (disable iff (rst)
    infoHit |-> pageSel[7] && progAddr[15:9] == 7'h7F)
    else $error("information area mapped wrongly");
  chk_bad_order: assert property (disable iff (rst)
    (state == S_FIRST) && wrState && wrByte != KEY_SECOND |=> statusCode == ST_LOCKED)
    else $error("broken unlock order not relocked");
  chk_sector_relock: assert property (disable iff (rst)
    (state == S_SECTOR) && wrState |=> statusCode == ST_LOCKED)
    else $error("sector state not relocked");
  chk_erase_span: assert property (disable iff (rst)
    pageEraseStart |=> opBusy ##[1:PAGE_MAX] statusCode == ST_UNLOCKED)
    else $error("page erase span wrong");
endmodule : flash_unlock_page_select

// [testbench/flash_unlock_page_select_bench.sv]
// self-checking bench for the flash unlock sequencer and page select
`timescale 1ns/1ps
module flash_unlock_page_select_bench;
  import flash_seq_pkg::*;
  localparam logic [15:0] A_ST = {2'b00, IDX_STATE, 2'b00};
  localparam logic [15:0] A_PG = {2'b00, IDX_PAGE, 2'b00};
  localparam logic [15:0] A_PD = {2'b00, IDX_PDATA, 2'b00};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] progAddr = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, pageMatch, infoHit, opBusy;
  logic progStart, pageEraseStart, massEraseStart;
  logic [6:0] erasePage;
  logic [7:0] progData, sectorProtect;
  logic [31:0] rdv;
  logic errv;
  int fail_count = 0;
  int checks_done = 0;

  always #10 clock = ~clock;

  flash_unlock_page_select #(.PROG_LEN(12'h004), .PAGE_LEN(12'h008), .MASS_LEN(12'h010)) i_dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .progAddr(progAddr), .pageMatch(pageMatch), .infoHit(infoHit),
    .erasePage(erasePage), .opBusy(opBusy), .progStart(progStart), .progData(progData),
    .pageEraseStart(pageEraseStart), .massEraseStart(massEraseStart),
    .sectorProtect(sectorProtect)
  );

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // wait for the access edge; the wait ends on the first edge that sees pready high
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let registered outputs settle before anyone looks at them
    @(negedge clock);
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, {24'h0, e});
  endtask : rd

  task automatic probe(input logic [15:0] pa);
    @(posedge clock);
    progAddr <= pa;
    @(negedge clock);
  endtask : probe

  task automatic unlock(input logic [7:0] p);
    wr(A_ST, KEY_FIRST);
    wr(A_ST, KEY_SECOND);
    wr(A_PG, p);
  endtask : unlock

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(A_ST, {2'b00, ST_LOCKED});
    rd(A_PG, PAGE_SEL_RESET);
  endtask : t_reset

  task automatic t_unlock;
    wr(A_ST, KEY_FIRST);
    rd(A_ST, {2'b00, ST_FIRST});
    wr(A_ST, KEY_SECOND);
    rd(A_ST, {2'b00, ST_SECOND});
    wr(A_PG, 8'h85);
    rd(A_ST, {2'b00, ST_UNLOCKED});
    rd(A_PG, 8'h85);
    chk(32'(erasePage), 32'h05);
    probe(16'h0BFF);
    chk(32'(pageMatch), 32'h1);
    probe(16'h0C00);
    chk(32'(pageMatch), 32'h0);
    probe(16'hFE00);
    chk(32'(infoHit), 32'h1);
    wr(A_PG, 8'h7A);
    rd(A_PG, 8'h7A);
    chk(32'(infoHit), 32'h0);
  endtask : t_unlock

  task automatic t_break;
    wr(A_ST, 8'h00);
    rd(A_ST, {2'b00, ST_LOCKED});
    wr(A_ST, KEY_FIRST);
    rd(A_ST, {2'b00, ST_FIRST});
    wr(A_ST, 8'h55);
    rd(A_ST, {2'b00, ST_LOCKED});
    wr(A_ST, KEY_FIRST);
    wr(A_ST, KEY_SECOND);
    wr(A_ST, KEY_SECOND);
    rd(A_ST, {2'b00, ST_LOCKED});
  endtask : t_break

  task automatic t_sector;
    unlock(8'h00);
    wr(A_ST, KEY_SECTOR);
    rd(A_ST, {2'b00, ST_SECTOR});
    wr(A_PG, 8'hA5);
    chk(32'(sectorProtect), 32'hA5);
    rd(A_ST, {2'b00, ST_UNLOCKED});
    rd(A_PG, 8'h00);
  endtask : t_sector

  task automatic t_ops;
    for (int i = 0; i < 3; i++) begin
      if (i == 0) wr(A_PD, 8'h3C);
      else wr(A_ST, (i == 1) ? CMD_PAGE_ERASE : CMD_MASS_ERASE);
      apb(1'b0, A_ST, 32'h0);
      chk(32'(rdv[5:3]), 32'(1 << i));
      chk(32'(opBusy), 32'h1);
      while (opBusy !== 1'b0) begin
        @(negedge clock);
      end
      rd(A_ST, {2'b00, ST_UNLOCKED});
    end
    chk(32'(progData), 32'h3C);
  endtask : t_ops

  task automatic t_unmapped;
    apb(1'b0, 16'h0100, 32'h0);
    chk(32'(errv), 32'h1);
    chk(rdv, 32'h0);
    pstrb <= 4'h0;
    wr(A_PG, 8'h5A);
    pstrb <= 4'hF;
    rd(A_PG, 8'h00);
  endtask : t_unmapped

  // ----------------------------------------------------------------
  // verdict and sequence
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #(20 * 5000);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_unlock();
    t_break();
    t_sector();
    t_ops();
    t_unmapped();
    finish_test();
  end
endmodule : flash_unlock_page_select_bench
